// >>> hdl/cmpadc_top.sv
/*
 Compare unit with special-event trigger and the converter control register.
 Assumes the timer counts on an external increment enable from logic on the
 same clock, and that the analog comparator answers combinationally.
*/
module cmpadc_top (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic timer_inc,
   input wire logic sleep_mode,
   input wire logic rc_osc_tick,
   input wire logic comparator_above,
   output logic compare_output_pin,
   output logic [2:0] analog_channel,
   output logic [7:0] dac_trial,
   output logic converter_powered,
   output logic special_event
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] compare_control_reg_r;
   logic [15:0] compare_value_reg_r;
   logic [15:0] timer_pair_r;
   logic [7:0] converter_control_zero_r;
   logic [7:0] conversion_result_reg_r;
   logic compare_match_flag_r;
   logic timer_overflow_flag_r;
   logic conv_done_flag_r;
   logic out_latch_r;
   logic invert_r;
   logic [7:0] tad_cnt_r;
   logic tad_tick;
   logic conv_tick;
   logic match;
   logic match_d_r;
   logic match_evt;
   logic is_compare_mode;
   logic [3:0] mode;
   logic trig;
   logic timer_wr;
   logic [2:0] chan_field;
   logic [1:0] clksel_field;
   logic sar_busy;
   logic sar_done;
   logic [7:0] sar_trial;
   logic go_bit;
   logic power_bit;
   logic sar_start;
   logic sar_abort;
   logic [7:0] rdata_nxt;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // Match detection
   // ------------------------------------------------------------
   assign mode = compare_control_reg_r[3:0];
   assign is_compare_mode = (mode[3:2] == 2'b10);
   assign match = is_compare_mode && (timer_pair_r == compare_value_reg_r);
   // One event per arrival at the match value, so a stopped timer gives one pulse
   assign match_evt = match && !match_d_r;
   assign trig = match_evt && (mode == cmpadc_pkg::CMPADC_MODE_SPECIAL);
   assign go_bit = converter_control_zero_r[cmpadc_pkg::CMPADC_CC0_GO_BIT];
   assign power_bit = converter_control_zero_r[cmpadc_pkg::CMPADC_CC0_POWER_BIT];
   assign chan_field = converter_control_zero_r[cmpadc_pkg::CMPADC_CC0_CHAN_LSB +: 3];
   assign clksel_field = converter_control_zero_r[cmpadc_pkg::CMPADC_CC0_CLKSEL_LSB +: 2];
   // A timer write in the same cycle replaces the count, so no roll-over happens then
   assign timer_wr = wr_stb && (hit(addr, cmpadc_pkg::CMPADC_OFS_TIMER_LO)
                                || hit(addr, cmpadc_pkg::CMPADC_OFS_TIMER_HI));

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         match_d_r <= 1'b0;
      end else begin
         match_d_r <= match;
      end
   end

   // ------------------------------------------------------------
   // Compare control and output latch
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         compare_control_reg_r <= cmpadc_pkg::CMPADC_RST_CMP_CTRL;
         compare_value_reg_r <= cmpadc_pkg::CMPADC_RST_CMP_VAL;
      end else if (wr_stb) begin
         if (hit(addr, cmpadc_pkg::CMPADC_OFS_CMP_CTRL)) begin
            compare_control_reg_r <= wdata;
         end
         if (hit(addr, cmpadc_pkg::CMPADC_OFS_CMP_VAL_LO)) begin
            compare_value_reg_r[7:0] <= wdata;
         end
         if (hit(addr, cmpadc_pkg::CMPADC_OFS_CMP_VAL_HI)) begin
            compare_value_reg_r[15:8] <= wdata;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         invert_r <= 1'b0;
      end else if (wr_stb && hit(addr, cmpadc_pkg::CMPADC_OFS_CMP_CTRL)
                   && mode == cmpadc_pkg::CMPADC_MODE_CLR_ON_MATCH
                   && wdata[3:0] == cmpadc_pkg::CMPADC_MODE_SET_ON_MATCH) begin
         // Sticky until reset, a known quirk kept for software compatibility
         invert_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         out_latch_r <= 1'b0;
      end else if (wr_stb && hit(addr, cmpadc_pkg::CMPADC_OFS_CMP_CTRL) && wdata == 8'h00) begin
         out_latch_r <= 1'b0;
      end else if (match_evt) begin
         unique case (mode)
            cmpadc_pkg::CMPADC_MODE_SET_ON_MATCH: out_latch_r <= 1'b1;
            cmpadc_pkg::CMPADC_MODE_CLR_ON_MATCH: out_latch_r <= 1'b0;
            default: out_latch_r <= out_latch_r;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         compare_output_pin <= 1'b0;
         special_event <= 1'b0;
      end else begin
         compare_output_pin <= out_latch_r ^ invert_r;
         special_event <= trig;
      end
   end

   // ------------------------------------------------------------
   // Timer pair
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_pair_r <= cmpadc_pkg::CMPADC_RST_TIMER;
      end else if (wr_stb && hit(addr, cmpadc_pkg::CMPADC_OFS_TIMER_LO)) begin
         // A software write to the timer wins over a coincident trigger
         timer_pair_r[7:0] <= wdata;
      end else if (wr_stb && hit(addr, cmpadc_pkg::CMPADC_OFS_TIMER_HI)) begin
         timer_pair_r[15:8] <= wdata;
      end else if (trig) begin
         timer_pair_r <= cmpadc_pkg::CMPADC_RST_TIMER;
      end else if (timer_inc) begin
         timer_pair_r <= timer_pair_r + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Flags: hardware set wins over software clear
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         compare_match_flag_r <= 1'b0;
         timer_overflow_flag_r <= 1'b0;
         conv_done_flag_r <= 1'b0;
      end else begin
         if (wr_stb && hit(addr, cmpadc_pkg::CMPADC_OFS_FLAGS)) begin
            compare_match_flag_r <= wdata[cmpadc_pkg::CMPADC_FLG_MATCH_BIT];
            timer_overflow_flag_r <= wdata[cmpadc_pkg::CMPADC_FLG_TIMER_OVF_BIT];
            conv_done_flag_r <= wdata[cmpadc_pkg::CMPADC_FLG_CONV_DONE_BIT];
         end
         if (match_evt) begin
            compare_match_flag_r <= 1'b1;
         end
         // Roll-over only; trigger clears are not overflows
         if (timer_inc && !trig && !timer_wr && timer_pair_r == 16'hffff) begin
            timer_overflow_flag_r <= 1'b1;
         end
         if (sar_done) begin
            conv_done_flag_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Converter control and conversion clock
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         converter_control_zero_r <= cmpadc_pkg::CMPADC_RST_CONV_CTRL0;
      end else begin
         if (wr_stb && hit(addr, cmpadc_pkg::CMPADC_OFS_CONV_CTRL0)) begin
            converter_control_zero_r <= wdata & cmpadc_pkg::CMPADC_CC0_WMASK;
         end
         // Power-off aborts the engine, so a pending go would only restart it stale
         if (sar_done || !power_bit) begin
            converter_control_zero_r[cmpadc_pkg::CMPADC_CC0_GO_BIT] <= 1'b0;
         end
         if (trig) begin
            converter_control_zero_r[cmpadc_pkg::CMPADC_CC0_GO_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || !power_bit) begin
         tad_cnt_r <= 8'h00;
      end else if (tad_tick) begin
         tad_cnt_r <= 8'h00;
      end else begin
         tad_cnt_r <= tad_cnt_r + 8'h01;
      end
   end

   assign tad_tick = (tad_cnt_r == 8'(cmpadc_pkg::CMPADC_TAD_CYC - 1));
   // In sleep the system divider stops, so only the RC oscillator can finish a conversion
   assign conv_tick = (clksel_field == cmpadc_pkg::CMPADC_CLKSEL_RC)
                      ? rc_osc_tick : (tad_tick && !sleep_mode);
   // Go is still set in the cycle that done stands; without this the engine would run again
   assign sar_start = power_bit && go_bit && !sar_busy && !sar_done;
   assign sar_abort = !power_bit;

   cmpadc_sar u_sar (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(sar_start),
      .abort(sar_abort),
      .tick(conv_tick),
      .cmp_above(comparator_above),
      .trial(sar_trial),
      .busy(sar_busy),
      .done(sar_done)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         conversion_result_reg_r <= cmpadc_pkg::CMPADC_RST_RESULT;
      end else if (sar_done) begin
         conversion_result_reg_r <= sar_trial;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         analog_channel <= 3'h0;
         dac_trial <= 8'h00;
         converter_powered <= 1'b0;
      end else begin
         // Codes above 4 select no input; hold channel 4 as the last legal one
         analog_channel <= (chan_field > cmpadc_pkg::CMPADC_CHAN_MAX)
                           ? cmpadc_pkg::CMPADC_CHAN_MAX : chan_field;
         dac_trial <= sar_trial;
         converter_powered <= power_bit;
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      unique case (addr)
         cmpadc_pkg::CMPADC_OFS_CMP_CTRL: rdata_nxt = compare_control_reg_r;
         cmpadc_pkg::CMPADC_OFS_CMP_VAL_LO: rdata_nxt = compare_value_reg_r[7:0];
         cmpadc_pkg::CMPADC_OFS_CMP_VAL_HI: rdata_nxt = compare_value_reg_r[15:8];
         cmpadc_pkg::CMPADC_OFS_TIMER_LO: rdata_nxt = timer_pair_r[7:0];
         cmpadc_pkg::CMPADC_OFS_TIMER_HI: rdata_nxt = timer_pair_r[15:8];
         cmpadc_pkg::CMPADC_OFS_FLAGS: rdata_nxt = {1'b0, conv_done_flag_r, 3'b000,
                                                     compare_match_flag_r, 1'b0, timer_overflow_flag_r};
         cmpadc_pkg::CMPADC_OFS_RESULT: rdata_nxt = conversion_result_reg_r;
         cmpadc_pkg::CMPADC_OFS_CONV_CTRL0: rdata_nxt = converter_control_zero_r;
         cmpadc_pkg::CMPADC_OFS_STATUS: rdata_nxt = {5'b00000, invert_r, sar_busy, out_latch_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         rdata <= rdata_nxt;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// >>> hdl/cmpadc_pkg.sv
/*
 Constants for the compare unit and its converter trigger: register offsets,
 field positions, reset values, mode codes and conversion timing.
 Assumes a single 40 MHz system clock and a plain address/strobe register port.
*/
package cmpadc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CMPADC_OFS_CMP_CTRL = 8'h17;
   localparam logic [7:0] CMPADC_OFS_CMP_VAL_LO = 8'h15;
   localparam logic [7:0] CMPADC_OFS_CMP_VAL_HI = 8'h16;
   localparam logic [7:0] CMPADC_OFS_TIMER_LO = 8'h0e;
   localparam logic [7:0] CMPADC_OFS_TIMER_HI = 8'h0f;
   localparam logic [7:0] CMPADC_OFS_FLAGS = 8'h0c;
   localparam logic [7:0] CMPADC_OFS_RESULT = 8'h1e;
   localparam logic [7:0] CMPADC_OFS_CONV_CTRL0 = 8'h1f;
   localparam logic [7:0] CMPADC_OFS_STATUS = 8'h20;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CMPADC_RST_CMP_CTRL = 8'h00;
   localparam logic [7:0] CMPADC_RST_CONV_CTRL0 = 8'h00;
   localparam logic [7:0] CMPADC_RST_RESULT = 8'h00;
   localparam logic [15:0] CMPADC_RST_CMP_VAL = 16'h0000;
   localparam logic [15:0] CMPADC_RST_TIMER = 16'h0000;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CMPADC_CC0_POWER_BIT = 0;
   localparam int CMPADC_CC0_GO_BIT = 2;
   localparam int CMPADC_CC0_CHAN_LSB = 3;
   localparam int CMPADC_CC0_CLKSEL_LSB = 6;
   localparam int CMPADC_FLG_TIMER_OVF_BIT = 0;
   localparam int CMPADC_FLG_MATCH_BIT = 2;
   localparam int CMPADC_FLG_CONV_DONE_BIT = 6;
   localparam logic [7:0] CMPADC_CC0_WMASK = 8'hfd;

   // ------------------------------------------------------------
   // Compare mode codes, conversion clock select and channel limit
   // ------------------------------------------------------------
   localparam logic [3:0] CMPADC_MODE_SET_ON_MATCH = 4'h8;
   localparam logic [3:0] CMPADC_MODE_CLR_ON_MATCH = 4'h9;
   localparam logic [3:0] CMPADC_MODE_SOFT_IRQ = 4'ha;
   localparam logic [3:0] CMPADC_MODE_SPECIAL = 4'hb;
   localparam logic [1:0] CMPADC_CLKSEL_RC = 2'h3;
   localparam logic [2:0] CMPADC_CHAN_MAX = 3'h4;

   // ------------------------------------------------------------
   // Converter timing
   // ------------------------------------------------------------
   localparam int CMPADC_SYS_CLK_HZ = 40000000;
   localparam int CMPADC_TAD_NS = 1600;
   localparam int CMPADC_TAD_CYC = (CMPADC_TAD_NS * (CMPADC_SYS_CLK_HZ / 1000000) + 999) / 1000;
   localparam int CMPADC_RESULT_BITS = 8;
   localparam int CMPADC_CHANNELS = 5;

   typedef enum logic [1:0] {CMPADC_IDLE, CMPADC_CONV, CMPADC_SLEEP_WAIT} cmpadc_conv_state_t;
endpackage

// >>> hdl/cmpadc_sar.sv
/*
 Successive-approximation engine for the converter: runs one bit per
 conversion clock tick and hands back an 8-bit result with a done pulse.
 Assumes an external comparator input answering for the current trial code.
*/
module cmpadc_sar (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic abort,
   input wire logic tick,
   input wire logic cmp_above,
   output logic [7:0] trial,
   output logic busy,
   output logic done
);
   logic [7:0] bit_r;
   logic [7:0] code_r;

   assign trial = code_r | bit_r;

   always_ff @(posedge sys_clk) begin
      done <= 1'b0;
      if (reset || abort) begin
         bit_r <= 8'h00;
         code_r <= 8'h00;
         busy <= 1'b0;
      end else if (start && !busy) begin
         bit_r <= 8'h80;
         code_r <= 8'h00;
         busy <= 1'b1;
      end else if (busy && tick) begin
         // Keep the trial bit while the sampled input stands above the trial level
         if (cmp_above) begin
            code_r <= code_r | bit_r;
         end
         bit_r <= bit_r >> 1;
         if (bit_r == 8'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
         end
      end
   end
endmodule

// >>> tb/cmpadc_assertions.sv
/*
 Port-level checker for the compare unit and converter control.
 Assumes binding into cmpadc_top, one clock, synchronous reset.
*/
module cmpadc_assertions (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic timer_inc,
   input wire logic sleep_mode,
   input wire logic rc_osc_tick,
   input wire logic comparator_above,
   input wire logic compare_output_pin,
   input wire logic [2:0] analog_channel,
   input wire logic [7:0] dac_trial,
   input wire logic converter_powered,
   input wire logic special_event
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Cause history
   // ----------------------------------------
   // A match needs timer or register motion 2 to 5 cycles before
   logic [4:0] hist_r;
   logic [1:0] cw_r;
   // Checks resume one edge late: reset falls by a non-blocking drive on an edge
   logic rst_q_r;
   always_ff @(posedge sys_clk) begin
      rst_q_r <= reset;
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hist_r <= 5'h00;
         cw_r <= 2'h0;
      end else begin
         hist_r <= {hist_r[3:0], timer_inc | wr_stb};
         cw_r <= {cw_r[0], wr_stb && addr == cmpadc_pkg::CMPADC_OFS_CONV_CTRL0};
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset || rst_q_r);
   a_event_pulse: assert property (special_event |=> !special_event)
      else $error("special event longer than one cycle");
   a_event_cause: assert property (special_event |-> |hist_r[4:1])
      else $error("special event without timer activity");
   a_pin_cause: assert property ($changed(compare_output_pin) |-> |hist_r[4:1])
      else $error("compare pin moved without cause");
   a_chan_range: assert property (analog_channel <= cmpadc_pkg::CMPADC_CHAN_MAX)
      else $error("channel out of range");
   a_chan_cause: assert property ($changed(analog_channel) |-> |cw_r)
      else $error("channel moved without a write");
   a_power_cause: assert property ($changed(converter_powered) |-> |cw_r)
      else $error("power moved without a write");
   a_trial_off: assert property (
      !converter_powered && !$past(converter_powered) && !$past(converter_powered, 2) |-> $stable(dac_trial))
      else $error("trial code moved while off");
   a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data outside read slot");
endmodule

bind cmpadc_top cmpadc_assertions u_chk (.sys_clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
   .timer_inc, .sleep_mode, .rc_osc_tick, .comparator_above, .compare_output_pin, .analog_channel,
   .dac_trial, .converter_powered, .special_event);

// >>> tb/cmpadc_far_end.sv
/*
 Far side model: timer increment source, RC conversion clock, comparator.
 Assumes the bench drives run and level on the system clock.
*/
module cmpadc_far_end (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic run,
   input wire logic [7:0] level,
   input wire logic [7:0] dac_trial,
   output logic timer_inc,
   output logic rc_osc_tick,
   output logic comparator_above
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] rc_cnt_r;
   // Timer is clocked synchronously, never from an async source
   always_ff @(posedge sys_clk) timer_inc <= run && !reset;
   always_ff @(posedge sys_clk) begin
      rc_cnt_r <= reset ? 2'h0 : rc_cnt_r + 2'h1;
      rc_osc_tick <= !reset && rc_cnt_r == 2'h3;
   end
   // Input sits half an LSB above level, so the ideal result is level
   assign comparator_above = dac_trial <= level;
endmodule

// >>> tb/compare_match_and_adc_trigger_bench.sv
/*
 Self-checking bench for cmpadc_top with the far side model.
 Assumes the register port and timing of the hand-over contract.
*/
module compare_match_and_adc_trigger_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CC0 = cmpadc_pkg::CMPADC_OFS_CONV_CTRL0;
   localparam logic [7:0] CCR = cmpadc_pkg::CMPADC_OFS_CMP_CTRL;
   localparam logic [7:0] FLG = cmpadc_pkg::CMPADC_OFS_FLAGS;
   localparam logic [7:0] STS = cmpadc_pkg::CMPADC_OFS_STATUS;
   localparam logic [7:0] RES = cmpadc_pkg::CMPADC_OFS_RESULT;
   logic sys_clk, reset, wr_stb, rd_stb, sleep_mode, run;
   logic timer_inc, rc_osc_tick, comparator_above, compare_output_pin, converter_powered, special_event;
   logic [7:0] addr, wdata, rdata, dac_trial, level;
   logic [7:0] ev_cnt = 8'h00;
   logic [2:0] analog_channel;
   int error_cnt, checks, cyc;
   logic [7:0] ra [5] = '{8'h15, 8'h16, CCR, CC0, 8'h00};
   logic [7:0] rw [5] = '{8'h34, 8'h12, 8'h0a, 8'hfa, 8'h55};
   logic [7:0] re [5] = '{8'h34, 8'h12, 8'h0a, 8'hf8, 8'h00};

   cmpadc_top DUT (.sys_clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .timer_inc, .sleep_mode,
      .rc_osc_tick, .comparator_above, .compare_output_pin, .analog_channel, .dac_trial,
      .converter_powered, .special_event);
   cmpadc_far_end far_u (.sys_clk, .reset, .run, .level, .dac_trial, .timer_inc, .rc_osc_tick,
      .comparator_above);

   // ----------------------------------------
   // Clock, timeout, event count
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (special_event === 1'b1) ev_cnt++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk(n, rdata, e);
   endtask
   // The pin is read as a driven output, as if its direction bit were cleared
   task automatic pchk(input logic e);
      repeat (2) @(posedge sys_clk);
      #1 chk("pin", {7'h00, compare_output_pin}, {7'h00, e});
   endtask
   // Timer held still while set up, so exactly one match at 0x0140
   task automatic cmp_run(input logic [7:0] mode);
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(FLG, 8'h00);
      wr(CCR, mode);
      @(posedge sys_clk) run <= 1'b1;
      repeat (400) @(posedge sys_clk);
      run <= 1'b0;
   endtask
   task automatic do_reset;
      @(posedge sys_clk) reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {reset, wr_stb, rd_stb, sleep_mode, run, addr, wdata, level} = '0;
      reset = 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rchk("ctrl0", CC0, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(ra[i], rw[i]);
         rchk("reg", ra[i], re[i]);
      end
      for (int c = 0; c < 5; c++) begin
         wr(CC0, 8'(c << 3));
         repeat (2) @(posedge sys_clk);
         #1 chk("chan", {5'h00, analog_channel}, 8'(c));
      end
      wr(8'h15, 8'h40);
      wr(8'h16, 8'h01);
      cmp_run(8'h08);
      pchk(1'b1);
      rchk("flags", FLG, 8'h04);
      cmp_run(8'h09);
      pchk(1'b0);
      rchk("flags", FLG, 8'h04);
      cmp_run(8'h0a);
      pchk(1'b0);
      rchk("flags", FLG, 8'h04);
      wr(CCR, 8'h09);
      wr(CCR, 8'h08);
      pchk(1'b1);
      rchk("status", STS, 8'h04);
      cmp_run(8'h08);
      pchk(1'b0);
      wr(CCR, 8'h00);
      pchk(1'b1);
      rchk("status", STS, 8'h04);
      wr(CC0, 8'h01);
      level <= 8'h5a;
      @(posedge sys_clk);
      #1 chk("powered", {7'h00, converter_powered}, 8'h01);
      cmp_run(8'h0b);
      chk("events", ev_cnt, 8'h01);
      rchk("timer hi", 8'h0f, 8'h00);
      rchk("flags", FLG, 8'h04);
      rchk("ctrl0", CC0, 8'h05);
      repeat (700) @(posedge sys_clk);
      rchk("ctrl0", CC0, 8'h01);
      rchk("result", RES, 8'h5a);
      rchk("flags", FLG, 8'h44);
      rchk("status", STS, 8'h04);
      sleep_mode <= 1'b1;
      wr(CC0, 8'h05);
      repeat (700) @(posedge sys_clk);
      rchk("ctrl0", CC0, 8'h05);
      rchk("status", STS, 8'h06);
      wr(CC0, 8'h00);
      rchk("ctrl0", CC0, 8'h00);
      chk("powered", {7'h00, converter_powered}, 8'h00);
      level <= 8'ha5;
      wr(CC0, 8'hc1);
      wr(CC0, 8'hc5);
      repeat (200) @(posedge sys_clk);
      rchk("ctrl0", CC0, 8'hc1);
      rchk("result", RES, 8'ha5);
      sleep_mode <= 1'b0;
      wr(CC0, 8'h05);
      repeat (20) @(posedge sys_clk);
      do_reset;
      rchk("ctrl0", CC0, 8'h00);
      rchk("result", RES, 8'h00);
      rchk("status", STS, 8'h00);
      pchk(1'b0);
      chk("trial", dac_trial, 8'h00);
      wrap_up;
   end
endmodule
